// ---- verification/pps_link_properties.sv ----
`timescale 1ns/1ps
module pps_link_properties
	import pps_pkg::*;
#(
	parameter int CYC_PER_MS = MS_CYC
) (
	// Clock and reset
	input wire logic             mclk,
	input wire logic             rst_b,
	// Link signals
	input wire logic             scl,
	input wire logic             dev_sda_oe,
	input wire logic             power_enable_in,
	input wire logic             power_hold_in,
	input wire logic             push_button_status_n,
	input wire logic             system_reset_out_n,
	input wire logic             interrupt_out_n,
	// Device pins
	input wire logic             push_button_in_n,
	input wire logic             push_button_hard_n,
	input wire logic [NRAIL-1:0] rail_pok,
	input wire logic [NRAIL-1:0] rail_en
);
	localparam int B_LO = 2 * CYC_PER_MS - 2;
	localparam int B_HI = 2 * CYC_PER_MS + 2;
	localparam int L_LO = 4 * CYC_PER_MS - 2;
	localparam int L_HI = 4 * CYC_PER_MS + 2;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ============================================================
	// Pins
	chk_status_press: assert property (
		$fell(push_button_in_n) |-> ##[1:4] !push_button_status_n)
		else $error("status pin missed a press");
	chk_hard_reset: assert property (
		$fell(push_button_hard_n) |-> ##[1:4] !system_reset_out_n)
		else $error("hard press did not pull reset low");
	chk_hard_hold: assert property (
		!push_button_hard_n [*5] |-> !system_reset_out_n)
		else $error("reset released during hard press");
	chk_reset_rail_good: assert property (
		$rose(system_reset_out_n) |-> rail_pok[RAIL_BC] && rail_en[RAIL_BC])
		else $error("reset released without buck c good");
	chk_irq_after_reset: assert property (
		$rose(rst_b) |-> interrupt_out_n [*8])
		else $error("interrupt active straight after reset");
	chk_sda_scl_low: assert property (
		$changed(dev_sda_oe) |-> !scl)
		else $error("device moved data while clock high");
	// ============================================================
	// Sequencer
	chk_ramp_order: assert property (
		$rose(rail_en[RAIL_BC]) |-> (rail_en[RAIL_LB] && !rail_en[RAIL_BA]) ##1 !system_reset_out_n)
		else $error("first rails out of order");
	chk_seq_buck_b: assert property (
		$rose(rail_en[RAIL_BA]) |-> ##[B_LO:B_HI] $rose(rail_en[RAIL_BB]))
		else $error("buck b not two ms after buck a");
	chk_seq_lin_a: assert property (
		$rose(rail_en[RAIL_BB]) |-> ##[L_LO:L_HI] $rose(rail_en[RAIL_LA]))
		else $error("linear a not four ms after buck b");
	chk_follow_enable: assert property (
		(rail_en[RAIL_LA] && power_enable_in == $past(power_enable_in)) [*5]
		|-> rail_en[RAIL_LC] == power_enable_in && rail_en[RAIL_LD] == power_enable_in)
		else $error("linear c or d not following enable");
	chk_release_off: assert property (
		$rose(push_button_in_n) && !power_hold_in && !power_enable_in && rail_en[RAIL_BC]
		|-> ##[1:6] rail_en == '0)
		else $error("release without hold kept rails on");
endmodule // pps_link_properties

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import pps_pkg::*;
;
	localparam int CPM = 20;
	localparam int RMS = 3;
	logic             mclk = 1'b0;
	logic             rst_b = 1'b0;
	logic [2:0]       addr = 3'h0;
	logic [7:0]       wdata = 8'h00;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic             rd_d = 1'b0;
	logic [7:0]       rdata;
	logic             push_button_in_n = 1'b1;
	logic             push_button_hard_n = 1'b1;
	logic             sys_voltage_low_in = 1'b0;
	logic [NRAIL-1:0] rail_pok = '0;
	logic [NRAIL-1:0] rail_en;
	logic [NRAIL-1:0] en_d = '0;
	logic             rst_d = 1'b0;
	logic [15:0]      lfsr = 16'h07f6;
	logic [7:0]       exp_q[$];
	logic [7:0]       msk_q[$];
	int               rise_cyc[NRAIL+1];
	int               cyc = 0;
	int               mismatches = 0;
	int               check_count = 0;
	pps_link_if pps_link_if_inst ();
	wire sys_rst_n = pps_link_if_inst.system_reset_out_n;
	wire irq_n     = pps_link_if_inst.interrupt_out_n;
	// ============================================================
	// Design and checker
	pps_device #(.CYC_PER_MS(CPM), .RST_MS(RMS)) pps_device_inst (
		.mclk(mclk), .rst_b(rst_b), .lnk(pps_link_if_inst),
		.push_button_in_n(push_button_in_n), .push_button_hard_n(push_button_hard_n),
		.rail_pok(rail_pok), .sys_voltage_low_in(sys_voltage_low_in), .rail_en(rail_en)
	);
	pps_host pps_host_inst (
		.mclk(mclk), .rst_b(rst_b), .lnk(pps_link_if_inst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
	);
	pps_link_properties #(.CYC_PER_MS(CPM)) pps_link_properties_inst (
		.mclk(mclk), .rst_b(rst_b),
		.scl(pps_link_if_inst.scl), .dev_sda_oe(pps_link_if_inst.dev_sda_oe),
		.power_enable_in(pps_link_if_inst.power_enable_in),
		.power_hold_in(pps_link_if_inst.power_hold_in),
		.push_button_status_n(pps_link_if_inst.push_button_status_n),
		.system_reset_out_n(sys_rst_n), .interrupt_out_n(irq_n),
		.push_button_in_n(push_button_in_n), .push_button_hard_n(push_button_hard_n),
		.rail_pok(rail_pok), .rail_en(rail_en)
	);
	// ============================================================
	// Clock, rail model and monitors
	always #5 mclk = ~mclk;
	// Rails report good one cycle after being enabled
	always @(posedge mclk) begin
		rail_pok <= en_d;
		rd_d     <= rd;
	end
	always @(negedge mclk) begin
		cyc   <= cyc + 1;
		en_d  <= rail_en;
		rst_d <= sys_rst_n;
		for (int i = 0; i < NRAIL; i++) begin
			if (rail_en[i] && !en_d[i]) begin
				rise_cyc[i] <= cyc;
			end
		end
		if (sys_rst_n && !rst_d) begin
			rise_cyc[NRAIL] <= cyc;
		end
		if (rd_d && exp_q.size() > 0) begin
			if (msk_q[0] !== 8'h00) begin
				cmp(rdata & msk_q[0], exp_q[0]);
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	// ============================================================
	// Tasks
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic in_range(input int v, input int t);
		cmp({7'h00, v >= (t - 1) * CPM * 88 / 100 && v <= t * CPM * 112 / 100 + 8}, 8'h01);
	endtask
	task automatic cycles(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic hwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask
	// A zero mask marks a poll whose value is not compared
	task automatic hrd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
		output logic [7:0] got);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge mclk);
		rd   <= 1'b0;
		@(negedge mclk);
		got = rdata;
	endtask
	task automatic i2c(input logic [7:0] r, input logic [7:0] d, input logic isrd);
		logic [7:0] s;
		s = 8'h01;
		hwr(HREG_RADDR, r);
		hwr(HREG_WDATA, d);
		hwr(HREG_GO, {7'h00, isrd});
		for (int n = 0; n < 8000 && s[ST_BUSY] !== 1'b0; n++) hrd(HREG_STAT, 8'h00, 8'h00, s);
		hrd(HREG_STAT, 8'h00, 8'h03, s);
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		logic [7:0] s;
		int n;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		hrd(HREG_STAT, 8'h00, 8'h17, s);
		hrd(3'h7, 8'h00, 8'hff, s);
		cmp({1'b0, rail_en}, 8'h00);
		// Soft press powers the rails up in order
		@(posedge mclk);
		push_button_in_n <= 1'b0;
		cycles(6);
		hrd(HREG_STAT, 8'h10, 8'h10, s);
		for (n = 0; n < 400 && !(rail_en[RAIL_LA] && sys_rst_n); n++) @(negedge mclk);
		cycles(1);
		in_range(rise_cyc[RAIL_BA] - rise_cyc[RAIL_BC], SEQ_A_MS);
		in_range(rise_cyc[RAIL_BB] - rise_cyc[RAIL_BC], SEQ_B_MS);
		in_range(rise_cyc[RAIL_LA] - rise_cyc[RAIL_BC], SEQ_LA_MS);
		in_range(rise_cyc[NRAIL] - rise_cyc[RAIL_BC], RMS);
		cmp({1'b0, rail_en}, 8'h1f);
		hwr(HREG_CTRL, 8'h01);
		@(posedge mclk);
		push_button_in_n <= 1'b1;
		cycles(10);
		cmp({1'b0, rail_en}, 8'h1f);
		hwr(HREG_CTRL, 8'h03);
		cycles(8);
		cmp({1'b0, rail_en}, 8'h7f);
		hwr(HREG_CTRL, 8'h01);
		cycles(8);
		cmp({1'b0, rail_en}, 8'h1f);
		// Hard press of random length
		lfsr = lfsr_next(lfsr);
		@(posedge mclk);
		push_button_in_n   <= 1'b0;
		push_button_hard_n <= 1'b0;
		cycles(6);
		cmp({7'h00, sys_rst_n}, 8'h00);
		cycles(CPM * RMS + int'(lfsr[5:0]));
		cmp({7'h00, sys_rst_n}, 8'h00);
		@(posedge mclk);
		push_button_in_n   <= 1'b1;
		push_button_hard_n <= 1'b1;
		for (n = 0; n < 200 && !sys_rst_n; n++) @(negedge mclk);
		cmp({7'h00, sys_rst_n}, 8'h01);
		cmp({1'b0, rail_en}, 8'h1f);
		// Masked, then unmasked level interrupt
		@(posedge mclk);
		sys_voltage_low_in <= 1'b1;
		cycles(8);
		cmp({7'h00, irq_n}, 8'h01);
		i2c(DREG_SYS, 8'h06, 1'b0);
		cmp({7'h00, irq_n}, 8'h00);
		hrd(HREG_STAT, 8'h04, 8'h04, s);
		@(posedge mclk);
		sys_voltage_low_in <= 1'b0;
		cycles(4);
		i2c(DREG_SYS, 8'h00, 1'b1);
		hrd(HREG_RDATA, 8'h06, 8'h0f, s);
		cycles(2);
		cmp({7'h00, irq_n}, 8'h01);
		i2c(DREG_EN, 8'h00, 1'b1);
		hrd(HREG_RDATA, 8'h1f, 8'hff, s);
		// Master off
		i2c(DREG_SYS, 8'h01, 1'b0);
		cycles(4);
		cmp({1'b0, rail_en}, 8'h00);
		// Early release without hold shuts down
		hwr(HREG_CTRL, 8'h00);
		lfsr = lfsr_next(lfsr);
		@(posedge mclk);
		push_button_in_n <= 1'b0;
		for (n = 0; n < 50 && !rail_en[RAIL_BC]; n++) @(negedge mclk);
		cycles(int'(lfsr[3:0]) + 2);
		cmp({1'b0, rail_en}, 8'h14);
		@(posedge mclk);
		push_button_in_n <= 1'b1;
		cycles(8);
		cmp({1'b0, rail_en}, 8'h00);
		finish_test;
	end
	initial begin
		#600_000;
		mismatches++;
		finish_test;
	end
endmodule // tb_top

// ---- verilog/pps_device.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Hard button press drives reset low immediately
// - Soft button press starts the power-up sequence
// - Status pin low while button is pressed
// - Reset held until timeout after rail C good
// - Unmasked interrupt pulls interrupt line low
// - Interrupt sources reset masked, unmasked by host
// - Release without hold or enable shuts down
// - Start buck C and linear B, reset low
// - Rails A, B, linear A at 2/4/8 ms
// - Reset released when timer done, rail good
// - Linear C and D follow the enable input
// - Host raises hold input during boot
// - Master-off write shuts the system down
// - Sequencing delays stay inside the stated tolerance; here the free-running tick can make them short by under a millisecond
// - Slave answers only at its fixed address
// - Single-byte register writes and reads served
// - START, MSB-first bytes, rising-edge sampling, acknowledge
// - Host reports interrupt, reset and button lines in status bits
module pps_device
	import pps_pkg::*;
#(
	parameter int CYC_PER_MS = MS_CYC,
	parameter int RST_MS     = RST_TIMEOUT_MS
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_b,
	// Link to the processor
	pps_link_if.dev               lnk,
	// Push-button pin and its low-impedance detector
	input  wire logic             push_button_in_n,
	input  wire logic             push_button_hard_n,
	// Rail monitors
	input  wire logic [NRAIL-1:0] rail_pok,
	input  wire logic             sys_voltage_low_in,
	// Rail enables
	output logic      [NRAIL-1:0] rail_en
);
	localparam int SYW = NRAIL + 5;
	localparam int PW  = $clog2(CYC_PER_MS);
	localparam int SMW = $clog2(SEQ_LA_MS + 1);
	localparam int RW  = $clog2(RST_MS + 1);
	localparam logic [PW-1:0]  PRE_LAST = PW'(CYC_PER_MS - 1);
	localparam logic [SMW-1:0] T_A      = SMW'(SEQ_A_MS);
	localparam logic [SMW-1:0] T_B      = SMW'(SEQ_B_MS);
	localparam logic [SMW-1:0] T_LA     = SMW'(SEQ_LA_MS);
	localparam logic [RW-1:0]  T_RST    = RW'(RST_MS);

	// ============================================================
	// Input synchronisers
	logic [SYW-1:0]   sy1_ff;
	logic [SYW-1:0]   sy2_ff;
	logic             en_s;
	logic             hold_s;
	logic             pb_s;
	logic             hard_s;
	logic             low_s;
	logic [NRAIL-1:0] pok_s;
	logic             pb_prev_ff;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sy1_ff <= {2'h0, 2'h3, 1'b0, {NRAIL{1'b0}}};
			sy2_ff <= {2'h0, 2'h3, 1'b0, {NRAIL{1'b0}}};
		end else begin
			sy1_ff <= {lnk.power_enable_in, lnk.power_hold_in, push_button_in_n,
				push_button_hard_n, sys_voltage_low_in, rail_pok};
			sy2_ff <= sy1_ff;
		end
	end

	assign {en_s, hold_s, pb_s, hard_s, low_s, pok_s} = sy2_ff;

	wire hard_press = ~hard_s;
	wire press_edge = ~pb_s & pb_prev_ff;
	wire rel_edge   = pb_s & ~pb_prev_ff;
	wire soft_start = press_edge & hard_s;
	wire first_good = pok_s[RAIL_BC] & pok_s[RAIL_LB];

	// ============================================================
	// Millisecond timebase
	logic [PW-1:0]  pre_ff;
	logic [SMW-1:0] seq_ms_ff;
	logic [RW-1:0]  rst_ms_ff;
	wire ms_tick = (pre_ff == PRE_LAST);

	// ============================================================
	// Register port
	logic [7:0] s_addr;
	logic [7:0] s_wdata;
	logic       s_wr;
	logic       s_rd;
	logic [7:0] s_rdata;
	logic       lvl_um_ff;
	logic       flt_um_ff;
	logic       lvl_f_ff;
	logic       flt_f_ff;

	pps_i2c_slave u_slave (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.scl_i    (lnk.scl),
		.sda_i    (lnk.sda),
		.sda_oe   (lnk.dev_sda_oe),
		.reg_addr (s_addr),
		.wr_data  (s_wdata),
		.wr_stb   (s_wr),
		.rd_stb   (s_rd),
		.rd_data  (s_rdata)
	);

	wire wr_sys = s_wr && (s_addr == DREG_SYS);
	wire rd_sys = s_rd && (s_addr == DREG_SYS);
	wire moff   = wr_sys && s_wdata[SYS_MOFF];

	logic [7:0] sys_word;
	always_comb begin
		sys_word             = 8'h00;
		sys_word[SYS_LVL_UM] = lvl_um_ff;
		sys_word[SYS_FLT_UM] = flt_um_ff;
		sys_word[SYS_LOW]    = low_s;
		sys_word[SYS_LVL_F]  = lvl_f_ff;
		sys_word[SYS_FLT_F]  = flt_f_ff;
	end

	assign s_rdata = (s_addr == DREG_SYS) ? sys_word :
		(s_addr == DREG_POK) ? 8'(pok_s) :
		(s_addr == DREG_EN)  ? 8'(rail_en) : 8'h00;

	// ============================================================
	// Power state machine
	pps_pwr_t   state_ff;
	pps_pwr_t   nxt_state;
	logic [NRAIL-1:0] en_ff;
	logic [NRAIL-1:0] nxt_en;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
		P_OFF:  if (soft_start) nxt_state = P_RAMP;
		P_RAMP: if (first_good) nxt_state = P_SEQ;
		P_SEQ:  if (seq_ms_ff >= T_LA) nxt_state = P_ON;
		P_ON:   nxt_state = P_ON;
		default: nxt_state = P_OFF;
		endcase
		if (state_ff != P_OFF) begin
			if (rel_edge && !en_s && !hold_s)
				nxt_state = P_OFF;
			if (moff)
				nxt_state = P_OFF;
		end
	end

	wire live  = (state_ff != P_OFF);
	wire is_on = (state_ff == P_ON);
	wire in_sq = (state_ff == P_SEQ);

	always_comb begin
		nxt_en          = {NRAIL{1'b0}};
		nxt_en[RAIL_BC] = live;
		nxt_en[RAIL_LB] = live;
		nxt_en[RAIL_BA] = is_on || (in_sq && seq_ms_ff >= T_A);
		nxt_en[RAIL_BB] = is_on || (in_sq && seq_ms_ff >= T_B);
		nxt_en[RAIL_LA] = is_on || (in_sq && seq_ms_ff >= T_LA);
		nxt_en[RAIL_LC] = is_on && en_s;
		nxt_en[RAIL_LD] = is_on && en_s;
		if (nxt_state == P_OFF)
			nxt_en = {NRAIL{1'b0}};
	end

	// ============================================================
	// Reset timer
	wire rst_clear = !live || (state_ff == P_RAMP) || hard_press || !pok_s[RAIL_BC];
	wire rst_done  = (rst_ms_ff == T_RST) && pok_s[RAIL_BC] && !rst_clear;
	logic rst_oe_ff;

	// ============================================================
	// Sequential
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pb_prev_ff <= 1'b1;
			state_ff   <= P_OFF;
			en_ff      <= {NRAIL{1'b0}};
			pre_ff     <= {PW{1'b0}};
			seq_ms_ff  <= {SMW{1'b0}};
			rst_ms_ff  <= {RW{1'b0}};
			rst_oe_ff  <= 1'b1;
			lvl_um_ff  <= 1'b0;
			flt_um_ff  <= 1'b0;
			lvl_f_ff   <= 1'b0;
			flt_f_ff   <= 1'b0;
		end else begin
			pb_prev_ff <= pb_s;
			state_ff   <= nxt_state;
			en_ff      <= nxt_en;
			// Free-running tick: first interval may be short by under a millisecond
			pre_ff     <= ms_tick ? {PW{1'b0}} : pre_ff + 1'b1;
			if (!in_sq)
				seq_ms_ff <= {SMW{1'b0}};
			else if (ms_tick && seq_ms_ff < T_LA)
				seq_ms_ff <= seq_ms_ff + 1'b1;
			if (rst_clear)
				rst_ms_ff <= {RW{1'b0}};
			else if (ms_tick && rst_ms_ff != T_RST)
				rst_ms_ff <= rst_ms_ff + 1'b1;
			rst_oe_ff  <= !rst_done;
			if (wr_sys) begin
				lvl_um_ff <= s_wdata[SYS_LVL_UM];
				flt_um_ff <= s_wdata[SYS_FLT_UM];
			end
			// Set wins over clear-on-read
			lvl_f_ff   <= low_s || (lvl_f_ff && !rd_sys);
			flt_f_ff   <= (is_on && |(en_ff & ~pok_s)) || (flt_f_ff && !rd_sys);
		end
	end

	// ============================================================
	// Outputs
	assign rail_en          = en_ff;
	assign lnk.pb_status_oe = ~pb_s;
	assign lnk.sys_reset_oe = rst_oe_ff;
	assign lnk.irq_oe       = (lvl_f_ff && lvl_um_ff) || (flt_f_ff && flt_um_ff);
endmodule // pps_device

// ---- verilog/pps_host.sv ----
`timescale 1ns/1ps
module pps_host
	import pps_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Link to the power unit
	pps_link_if.host        lnk,
	// Register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata
);
	localparam int QW = $clog2(SCL_QTR_CYC);
	localparam logic [QW-1:0] QTR_LAST = QW'(SCL_QTR_CYC - 1);

	// ============================================================
	// Pin sampling and registers
	logic [3:0] sy1_ff;
	logic [3:0] sy2_ff;
	logic [1:0] ctrl_ff;
	logic [7:0] raddr_ff;
	logic [7:0] wdat_ff;
	logic       rdop_ff;
	logic       nack_ff;
	logic [7:0] rx_ff;
	logic [7:0] rdata_ff;
	pps_mst_t   state_ff;
	logic [QW-1:0] qcnt_ff;
	logic [1:0] q_ff;
	logic [3:0] bit_ff;
	logic [1:0] bi_ff;
	logic       scl_oe_ff;
	logic       sda_oe_ff;

	wire sda_s = sy2_ff[0];
	wire busy  = (state_ff != H_IDLE);
	wire go    = wr && (addr == HREG_GO) && !busy;
	wire tick  = busy && (qcnt_ff == QTR_LAST);
	wire last  = rdop_ff ? (bi_ff == IDX_OVER) : (bi_ff == IDX_DATA);

	// Byte sent in each slot; the read data slot is released
	function automatic logic [7:0] slot_byte(input logic [1:0] i, input logic r);
		slot_byte = (i == IDX_ADDR) ? {I2C_ADDR, 1'b0} :
			(i == IDX_REG) ? raddr_ff :
			(i == IDX_DATA) ? (r ? {I2C_ADDR, 1'b1} : wdat_ff) : 8'hff;
	endfunction

	wire [7:0] cur_byte = slot_byte(bi_ff, rdop_ff);
	wire txbit  = (bit_ff == BYTE_BITS) ? 1'b1 : cur_byte[3'(MSB_IDX - bit_ff)];
	wire scl_hi = !busy || ((state_ff == H_BIT) ? q_ff[1] : (q_ff != 2'h0));
	wire sda_lo = (state_ff == H_START) ? q_ff[1] :
		(state_ff == H_STOP) ? !q_ff[1] :
		(state_ff == H_BIT) ? !txbit : 1'b0;

	wire [7:0] stat = 8'({~sy2_ff[3], ~sy2_ff[2], ~sy2_ff[1], nack_ff, busy}
		<< ST_BUSY);
	wire [7:0] rd_mux = (addr == HREG_CTRL) ? 8'(ctrl_ff) :
		(addr == HREG_RADDR) ? raddr_ff :
		(addr == HREG_WDATA) ? wdat_ff :
		(addr == HREG_STAT) ? stat :
		(addr == HREG_RDATA) ? rx_ff : 8'h00;

	// ============================================================
	// Master sequencer
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sy1_ff    <= 4'hf;
			sy2_ff    <= 4'hf;
			ctrl_ff   <= 2'h0;
			raddr_ff  <= 8'h00;
			wdat_ff   <= 8'h00;
			rdop_ff   <= 1'b0;
			nack_ff   <= 1'b0;
			rx_ff     <= 8'h00;
			rdata_ff  <= 8'h00;
			state_ff  <= H_IDLE;
			qcnt_ff   <= {QW{1'b0}};
			q_ff      <= 2'h0;
			bit_ff    <= 4'h0;
			bi_ff     <= IDX_ADDR;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			sy1_ff    <= {lnk.push_button_status_n, lnk.system_reset_out_n,
				lnk.interrupt_out_n, lnk.sda};
			sy2_ff    <= sy1_ff;
			scl_oe_ff <= !scl_hi;
			sda_oe_ff <= sda_lo;
			if (rd)
				rdata_ff <= rd_mux;
			if (wr && addr == HREG_CTRL)
				ctrl_ff <= wdata[1:0];
			if (wr && addr == HREG_RADDR && !busy)
				raddr_ff <= wdata;
			if (wr && addr == HREG_WDATA && !busy)
				wdat_ff <= wdata;
			qcnt_ff   <= (tick || !busy) ? {QW{1'b0}} : qcnt_ff + 1'b1;
			if (go) begin
				state_ff <= H_START;
				rdop_ff  <= wdata[GO_RD];
				nack_ff  <= 1'b0;
				bi_ff    <= IDX_ADDR;
				q_ff     <= 2'h0;
			end else if (tick) begin
				q_ff <= q_ff + 2'h1;
				if (q_ff == Q_HI && state_ff == H_BIT) begin
					if (bit_ff != BYTE_BITS)
						rx_ff <= {rx_ff[6:0], sda_s};
					else if (sda_s && !(rdop_ff && last))
						nack_ff <= 1'b1;
				end
				if (q_ff == Q_LAST) begin
					case (state_ff)
					H_START: begin
						state_ff <= H_BIT;
						bit_ff   <= 4'h0;
					end
					H_BIT: begin
						bit_ff <= bit_ff + 4'h1;
						if (bit_ff == BYTE_BITS) begin
							bit_ff <= 4'h0;
							bi_ff  <= bi_ff + 2'h1;
							if (last || nack_ff)
								state_ff <= H_STOP;
							else if (rdop_ff && bi_ff == IDX_REG)
								state_ff <= H_START;
						end
					end
					default: state_ff <= H_IDLE;
					endcase
				end
			end
		end
	end

	assign lnk.host_scl_oe     = scl_oe_ff;
	assign lnk.host_sda_oe     = sda_oe_ff;
	assign lnk.power_hold_in   = ctrl_ff[CTRL_HOLD];
	assign lnk.power_enable_in = ctrl_ff[CTRL_EN];
	assign rdata               = rdata_ff;
endmodule // pps_host

// ---- verilog/pps_i2c_slave.sv ----
`timescale 1ns/1ps
module pps_i2c_slave
	import pps_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_oe,
	// Register access
	output logic [7:0]      reg_addr,
	output logic [7:0]      wr_data,
	output logic            wr_stb,
	output logic            rd_stb,
	input  wire logic [7:0] rd_data
);
	// ============================================================
	// Pin sampling
	logic [1:0] scl_sy_ff;
	logic [1:0] sda_sy_ff;
	logic       scl_d_ff;
	logic       sda_d_ff;
	pps_slv_t   state_ff;
	logic [3:0] cnt_ff;
	logic [1:0] idx_ff;
	logic       rw_ff;
	logic [7:0] sh_ff;
	logic [7:0] addr_ff;
	logic [7:0] wdata_ff;
	logic       oe_ff;
	logic       wr_ff;
	logic       rd_ff;
	wire scl_s     = scl_sy_ff[1];
	wire sda_s     = sda_sy_ff[1];
	wire scl_rise  = scl_s & ~scl_d_ff;
	wire scl_fall  = ~scl_s & scl_d_ff;
	wire start_c   = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_c    = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	wire byte_end  = scl_fall && (cnt_ff == BYTE_BITS);
	wire addr_miss = (idx_ff == IDX_ADDR) && (sh_ff[7:1] != I2C_ADDR);
	wire refuse    = addr_miss || (idx_ff == IDX_OVER);
	// ============================================================
	// Byte engine
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sy_ff <= 2'h3;
			sda_sy_ff <= 2'h3;
			scl_d_ff  <= 1'b1;
			sda_d_ff  <= 1'b1;
			state_ff  <= S_IDLE;
			cnt_ff    <= 4'h0;
			idx_ff    <= IDX_ADDR;
			rw_ff     <= 1'b0;
			sh_ff     <= 8'h00;
			addr_ff   <= 8'h00;
			wdata_ff  <= 8'h00;
			oe_ff     <= 1'b0;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
		end else begin
			scl_sy_ff <= {scl_sy_ff[0], scl_i};
			sda_sy_ff <= {sda_sy_ff[0], sda_i};
			scl_d_ff  <= scl_s;
			sda_d_ff  <= sda_s;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
			if (start_c) begin
				state_ff <= S_RX;
				cnt_ff   <= 4'h0;
				idx_ff   <= IDX_ADDR;
				oe_ff    <= 1'b0;
			end else if (stop_c) begin
				state_ff <= S_IDLE;
				oe_ff    <= 1'b0;
			end else begin
				case (state_ff)
				S_RX: begin
					if (scl_rise) begin
						sh_ff  <= {sh_ff[6:0], sda_s};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (byte_end) begin
						cnt_ff <= 4'h0;
						if (refuse) begin
							state_ff <= S_IDLE;
						end else begin
							state_ff <= S_ACK;
							oe_ff    <= 1'b1;
						end
						if (idx_ff == IDX_ADDR)
							rw_ff <= sh_ff[0];
						if (idx_ff == IDX_REG)
							addr_ff <= sh_ff;
						if (idx_ff == IDX_DATA) begin
							wdata_ff <= sh_ff;
							wr_ff    <= 1'b1;
						end
					end
				end
				S_ACK: begin
					if (scl_fall && rw_ff) begin
						state_ff <= S_TX;
						sh_ff    <= rd_data;
						oe_ff    <= ~rd_data[7];
						cnt_ff   <= 4'h1;
						rd_ff    <= 1'b1;
					end else if (scl_fall) begin
						state_ff <= S_RX;
						oe_ff    <= 1'b0;
						if (idx_ff != IDX_OVER)
							idx_ff <= idx_ff + 2'h1;
					end
				end
				S_TX: begin
					if (byte_end) begin
						oe_ff    <= 1'b0;
						state_ff <= S_RACK;
					end else if (scl_fall) begin
						oe_ff  <= ~sh_ff[6];
						sh_ff  <= {sh_ff[6:0], 1'b0};
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				S_RACK: begin
					if (scl_rise)
						state_ff <= S_IDLE;
				end
				default: state_ff <= S_IDLE;
				endcase
			end
		end
	end

	assign sda_oe   = oe_ff;
	assign reg_addr = addr_ff;
	assign wr_data  = wdata_ff;
	assign wr_stb   = wr_ff;
	assign rd_stb   = rd_ff;
endmodule // pps_i2c_slave

// ---- verilog/pps_link_if.sv ----
`timescale 1ns/1ps
interface pps_link_if;
	logic      host_scl_oe;
	logic      host_sda_oe;
	logic      dev_sda_oe;
	logic      power_enable_in;
	logic      power_hold_in;
	logic      pb_status_oe;
	logic      sys_reset_oe;
	logic      irq_oe;
	wire logic scl;
	wire logic sda;
	wire logic push_button_status_n;
	wire logic system_reset_out_n;
	wire logic interrupt_out_n;
	// Open-drain lines with pull-ups
	assign scl                  = ~host_scl_oe;
	assign sda                  = ~(host_sda_oe | dev_sda_oe);
	assign push_button_status_n = ~pb_status_oe;
	assign system_reset_out_n   = ~sys_reset_oe;
	assign interrupt_out_n      = ~irq_oe;
	modport dev (
		input  scl, sda, power_enable_in, power_hold_in,
		output dev_sda_oe, pb_status_oe, sys_reset_oe, irq_oe
	);
	modport host (
		input  scl, sda, push_button_status_n, system_reset_out_n, interrupt_out_n,
		output host_scl_oe, host_sda_oe, power_enable_in, power_hold_in
	);
endinterface // pps_link_if

// ---- verilog/pps_pkg.sv ----
package pps_pkg;
	// ============================================================
	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int MS_CYC         = 1000 * CLK_MHZ;
	localparam int RST_TIMEOUT_MS = 64;
	localparam int SEQ_A_MS       = 2;
	localparam int SEQ_B_MS       = 4;
	localparam int SEQ_LA_MS      = 8;
	localparam int SCL_KHZ        = 400;
	// Quarter of an SCL period, rounded up so SCL never exceeds its limit
	localparam int SCL_QTR_CYC    = (CLK_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
	// ============================================================
	// Serial link
	localparam logic [6:0] I2C_ADDR  = 7'h5b;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] MSB_IDX   = 4'h7;
	localparam logic [1:0] IDX_ADDR  = 2'h0;
	localparam logic [1:0] IDX_REG   = 2'h1;
	localparam logic [1:0] IDX_DATA  = 2'h2;
	localparam logic [1:0] IDX_OVER  = 2'h3;
	localparam logic [1:0] Q_LAST    = 2'h3;
	localparam logic [1:0] Q_HI      = 2'h2;
	// ============================================================
	// Rails
	localparam int NRAIL   = 7;
	localparam int RAIL_BA = 0;
	localparam int RAIL_BB = 1;
	localparam int RAIL_BC = 2;
	localparam int RAIL_LA = 3;
	localparam int RAIL_LB = 4;
	localparam int RAIL_LC = 5;
	localparam int RAIL_LD = 6;
	// ============================================================
	// Device registers
	localparam logic [7:0] DREG_SYS = 8'h00;
	localparam logic [7:0] DREG_POK = 8'h01;
	localparam logic [7:0] DREG_EN  = 8'h02;
	localparam int SYS_MOFF   = 0;
	localparam int SYS_LVL_UM = 1;
	localparam int SYS_FLT_UM = 2;
	localparam int SYS_LOW    = 3;
	localparam int SYS_LVL_F  = 4;
	localparam int SYS_FLT_F  = 5;
	// ============================================================
	// Host controller registers
	localparam logic [2:0] HREG_CTRL  = 3'h0;
	localparam logic [2:0] HREG_RADDR = 3'h1;
	localparam logic [2:0] HREG_WDATA = 3'h2;
	localparam logic [2:0] HREG_GO    = 3'h3;
	localparam logic [2:0] HREG_STAT  = 3'h4;
	localparam logic [2:0] HREG_RDATA = 3'h5;
	localparam int CTRL_HOLD = 0;
	localparam int CTRL_EN   = 1;
	localparam int GO_RD     = 0;
	localparam int ST_BUSY   = 0;
	localparam int ST_NACK   = 1;
	localparam int ST_IRQ    = 2;
	localparam int ST_RST    = 3;
	localparam int ST_PB     = 4;
	// ============================================================
	// States
	typedef enum logic [1:0] {
		P_OFF = 2'b00, P_RAMP = 2'b01, P_SEQ = 2'b11, P_ON = 2'b10
	} pps_pwr_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_RX = 3'b001, S_ACK = 3'b011, S_TX = 3'b010, S_RACK = 3'b110
	} pps_slv_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b11, H_STOP = 2'b10
	} pps_mst_t;
endpackage
